//--- include/iouds_defs.svh
// offsets, field positions, reset values and timing counts of the deadstart sequencer
`ifndef IOUDS_DEFS_SVH
`define IOUDS_DEFS_SVH
`define IOUDS_CTRL_OFF    12'h000
`define IOUDS_STAT_OFF    12'h004
`define IOUDS_CONF_OFF    12'h008
`define IOUDS_FOLD_OFF    12'h00C
`define IOUDS_EDIT_OFF    12'h010
`define IOUDS_BLOCK_OFF   12'h014
`define IOUDS_FAULT_OFF   12'h018
`define IOUDS_PROG_OFF    12'h040
`define IOUDS_CMD_QUICK   2'h1
`define IOUDS_CMD_EXT     2'h2
`define IOUDS_OPC_INIT    16'o007100
`define IOUDS_IC_INIT     16'o007777
`define IOUDS_WC_INIT     16'o010000
`define IOUDS_LT_ENTRY    16'o006000
`define IOUDS_TEST_DONE   16'o007776
`define IOUDS_LAST_WORD   12'o7777
`define IOUDS_PROG_LAST   12'o0021
`define IOUDS_MEM_SETTING 8'h00
`define IOUDS_BRL_SETTING 1'b0
`define IOUDS_FOLD_LO     20
`define IOUDS_FOLD_HI     23
`define IOUDS_CLK_MHZ     250
`define IOUDS_DIAG_S      15
`define IOUDS_DIAG_CYC    (`IOUDS_DIAG_S * `IOUDS_CLK_MHZ * 64'd1000000)
`endif

//--- include/iouds_pkg.sv
// types of the deadstart sequencer
package iouds_pkg;
  typedef enum logic [2:0] {
    IOUDS_IDLE  = 3'b000,
    IOUDS_CLEAR = 3'b001,
    IOUDS_WIPE  = 3'b011,
    IOUDS_DIAG  = 3'b010,
    IOUDS_LOAD  = 3'b110,
    IOUDS_START = 3'b111,
    IOUDS_HUNG  = 3'b101
  } iouds_state_e;
  typedef struct packed {
    logic        we;
    logic [4:0]  pp;
    logic [11:0] addr;
    logic [15:0] data;
  } iouds_mem_s;
  typedef struct packed {
    logic [15:0] opcode;
    logic [15:0] counter;
    logic [15:0] count;
    logic [4:0]  chan;
  } iouds_regs_s;
endpackage

//--- core/iouds_sequencer.sv
// deadstart sequencer of the io unit with its apb register file
// Operation
// - hold sixteen-word boot program for boot processor
// - word edit and block edit of program
// - fold switches force address bits 23..20
// - folded store answers contiguous addresses
// - extended key extended run, quick key quick
// - extended run adds fifteen-second rom diagnostic
// - master clear arms others for block input
// - master clear resets equipment, sets bit 52
// - channel 0 inactive, others active empty clear
// - clock channel flags hardwired
// - load opcode, counter, count, channel per processor
// - initial values in both barrels except boot
// - extended clears word 7777, sets entry point
// - hardware error hangs; 7776 ends with clear
// - clear word 0, copy 1..20, clear 21, start
// - quick run touches only boot words 0..21
// - others wait for block input at end
// - after block input start at word 0 address
// - logical numbers mapped circularly from rotation settings
// - reject rotation values beyond installed count
// - abort shows branch or data/address fault
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ns
`include "iouds_defs.svh"
module iouds_sequencer import iouds_pkg::*; #(
  parameter int          NUM_PP   = 20,
  parameter int          NUM_CHAN = 24,
  parameter logic [31:0] DIAG_CYC = 32'(`IOUDS_DIAG_CYC)
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // processor memory port
  output iouds_mem_s       memWrite,
  // processor register initialisation
  output logic             regLoad,
  output iouds_regs_s      regInit,
  output logic [4:0]       regPp,
  output logic             bootStart,
  output logic [15:0]      bootCounter,
  // diagnostic progress from the boot processor
  input  wire logic [15:0] bootPc,
  input  wire logic        diagBranchFail,
  input  wire logic        diagDataFail,
  // equipment and channels
  output logic             equipReset,
  output logic             maintBit52,
  output logic [NUM_CHAN-1:0] chanActive,
  output logic [NUM_CHAN-1:0] chanFull,
  output logic [NUM_CHAN-1:0] chanFlag,
  output logic [NUM_CHAN-1:0] chanErr,
  output logic [NUM_PP-1:0]   ppWaiting,
  input  wire logic [NUM_PP-1:0] blockDone,
  // main store address folding
  input  wire logic [27:0] storeAddrIn,
  output logic [27:0]      storeAddrOut
);
  localparam int CLK_CH = 12;  // channel 14 octal

  ////////////////////////////////////////////////////////////////////
  logic [15:0]  bootProg [16];
  logic [7:0]   memRotation;
  logic [4:0]   barrelRotation;
  logic [15:0]  entryPoint;
  logic [3:0]   foldForce;
  logic [3:0]   foldEnable;
  logic [3:0]   blockIdx;
  logic         confError;
  logic [1:0]   faultShow;
  logic         extRun;
  logic         secondClear;
  iouds_state_e state;
  logic [31:0]  timer;
  logic [11:0]  step;
  logic         apbDone;
  logic         keyQuick;
  logic         keyExt;

  function automatic logic [4:0] physPp(input logic [4:0] lg, input logic [7:0] rot);
    logic [5:0] sum;
    sum = 6'(lg) + 6'(rot[4:0]);
    if (sum >= 6'(NUM_PP)) begin
      sum = sum - 6'(NUM_PP);
    end
    return sum[4:0];
  endfunction

  assign apbDone = psel && penable && pready;
  assign keyQuick = apbDone && pwrite && paddr == `IOUDS_CTRL_OFF
                    && pwdata[1:0] == `IOUDS_CMD_QUICK;
  assign keyExt   = apbDone && pwrite && paddr == `IOUDS_CTRL_OFF
                    && pwdata[1:0] == `IOUDS_CMD_EXT;

  ////////////////////////////////////////////////////////////////////
  // apb: one wait state so every access answers in the second access cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memRotation    <= `IOUDS_MEM_SETTING;
      barrelRotation <= 5'(`IOUDS_BRL_SETTING);
      entryPoint     <= `IOUDS_LT_ENTRY;
      foldForce      <= 4'h0;
      foldEnable     <= 4'h0;
      blockIdx       <= 4'h0;
      confError      <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        bootProg[i] <= 16'h0000;
      end
    end else if (apbDone && pwrite && state == IOUDS_IDLE) begin
      unique case (paddr)
        `IOUDS_CONF_OFF: begin
          // out-of-range rotation is refused and flagged, rotation kept; entry point is still written
          if (pwdata[7:0] >= 8'(NUM_PP) || pwdata[8] && NUM_PP <= 10) begin
            confError <= 1'b1;
          end else begin
            memRotation    <= pwdata[7:0];
            barrelRotation <= {4'h0, pwdata[8]};
            confError      <= 1'b0;
          end
          entryPoint <= pwdata[31:16];
        end
        `IOUDS_FOLD_OFF: begin
          foldForce  <= pwdata[3:0];
          foldEnable <= pwdata[7:4];
        end
        `IOUDS_EDIT_OFF: begin
          bootProg[pwdata[19:16]] <= pwdata[15:0];
        end
        `IOUDS_BLOCK_OFF: begin
          if (pwdata[20]) begin
            blockIdx <= pwdata[19:16];
          end else begin
            bootProg[blockIdx] <= pwdata[15:0];
            blockIdx           <= blockIdx + 4'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          `IOUDS_CTRL_OFF:  prdata <= 32'h0000_0000;
          `IOUDS_STAT_OFF:  prdata <= {25'h0, confError, faultShow, extRun, state};
          `IOUDS_CONF_OFF:  prdata <= {entryPoint, 7'h0, barrelRotation[0], memRotation};
          `IOUDS_FOLD_OFF:  prdata <= {24'h0, foldEnable, foldForce};
          `IOUDS_FAULT_OFF: prdata <= {30'h0, faultShow};
          default: begin
            if (paddr[11:6] == 6'(`IOUDS_PROG_OFF >> 6) && paddr[1:0] == 2'h0) begin
              prdata <= {16'h0, bootProg[paddr[5:2]]};
            end else begin
              pslverr <= 1'b1;
            end
          end
        endcase
      end else if (!(paddr inside {`IOUDS_CTRL_OFF, `IOUDS_CONF_OFF, `IOUDS_FOLD_OFF,
                                  `IOUDS_EDIT_OFF, `IOUDS_BLOCK_OFF})) begin
        pslverr <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequence control
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state       <= IOUDS_IDLE;
      extRun      <= 1'b0;
      secondClear <= 1'b0;
      timer       <= 32'h0;
      step        <= 12'h000;
      faultShow   <= 2'h0;
    end else begin
      unique case (state)
        IOUDS_IDLE: begin
          if (keyExt || keyQuick) begin
            extRun      <= keyExt;
            secondClear <= 1'b0;
            faultShow   <= 2'h0;
            step        <= 12'h000;
            state       <= IOUDS_CLEAR;
          end
        end
        IOUDS_CLEAR: begin
          // one processor rank per cycle, mirrors the rank-by-rank numbering
          step <= step + 12'h001;
          if (step == 12'(NUM_PP - 1)) begin
            step  <= 12'h000;
            state <= extRun && !secondClear ? IOUDS_WIPE : IOUDS_LOAD;
          end
        end
        IOUDS_WIPE: begin
          step <= step + 12'h001;
          if (step == 12'(NUM_PP - 1)) begin
            step  <= 12'h000;
            timer <= 32'h0;
            state <= IOUDS_DIAG;
          end
        end
        IOUDS_DIAG: begin
          timer <= timer + 32'h1;
          if (diagBranchFail || diagDataFail || timer >= DIAG_CYC) begin
            faultShow <= {diagDataFail, diagBranchFail || !diagDataFail};
            state     <= IOUDS_HUNG;
          end else if (bootPc == `IOUDS_TEST_DONE) begin
            secondClear <= 1'b1;
            state       <= IOUDS_CLEAR;
          end
        end
        IOUDS_LOAD: begin
          step <= step + 12'h001;
          if (step == `IOUDS_PROG_LAST) begin
            step  <= 12'h000;
            state <= IOUDS_START;
          end
        end
        IOUDS_START: begin
          state <= IOUDS_IDLE;
        end
        IOUDS_HUNG: begin
          // an aborted run frees the keys again
          state <= IOUDS_IDLE;
        end
        default: begin
          state <= IOUDS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // memory writes, register init and start
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memWrite    <= '0;
      regLoad     <= 1'b0;
      regInit     <= '0;
      regPp       <= 5'h00;
      bootStart   <= 1'b0;
      bootCounter <= 16'h0000;
      equipReset  <= 1'b0;
      maintBit52  <= 1'b0;
    end else begin
      memWrite   <= '0;
      regLoad    <= 1'b0;
      bootStart  <= 1'b0;
      equipReset <= state == IOUDS_CLEAR;
      if (state == IOUDS_CLEAR) begin
        maintBit52 <= 1'b1;
      end
      // rank index covers both barrels; the boot rank is skipped
      if (state == IOUDS_CLEAR && step != 12'h000) begin
        regLoad <= 1'b1;
        regPp   <= physPp(step[4:0], memRotation + {3'h0, barrelRotation});
        regInit <= '{opcode: `IOUDS_OPC_INIT, counter: `IOUDS_IC_INIT,
                     count: `IOUDS_WC_INIT, chan: step[4:0]};
      end
      if (state == IOUDS_WIPE) begin
        memWrite <= '{we: 1'b1, pp: physPp(step[4:0], memRotation),
                      addr: `IOUDS_LAST_WORD, data: 16'h0000};
      end
      if (state == IOUDS_WIPE && step == 12'(NUM_PP - 1)) begin
        bootStart   <= 1'b1;
        bootCounter <= entryPoint;
      end
      if (state == IOUDS_LOAD) begin
        memWrite <= '{we: 1'b1, pp: physPp(5'h00, memRotation), addr: step,
                      data: (step == 12'h000 || step == `IOUDS_PROG_LAST) ? 16'h0000
                            : bootProg[4'(step - 12'h001)]};
      end
      if (state == IOUDS_START) begin
        bootStart   <= 1'b1;
        bootCounter <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // channel flags and waiting processors
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chanActive <= '0;
      chanFull   <= '0;
      chanFlag   <= '0;
      chanErr    <= '0;
      ppWaiting  <= '0;
    end else begin
      if (state == IOUDS_CLEAR) begin
        chanActive <= {NUM_CHAN{1'b1}};
        chanActive[0] <= 1'b0;
        chanFull   <= '0;
        chanFlag   <= '0;
        chanErr    <= '0;
        ppWaiting  <= {{(NUM_PP-1){1'b1}}, 1'b0};
      end else begin
        ppWaiting <= ppWaiting & ~blockDone;
      end
      chanActive[CLK_CH] <= 1'b1;
      chanFull[CLK_CH]   <= 1'b1;
      chanFlag[CLK_CH]   <= 1'b1;
      chanErr[CLK_CH]    <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      storeAddrOut <= 28'h0;
    end else begin
      storeAddrOut <= storeAddrIn;
      for (int b = 0; b < 4; b++) begin
        if (foldEnable[b]) begin
          storeAddrOut[`IOUDS_FOLD_LO + b] <= foldForce[b];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  busy_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    state != IOUDS_IDLE && state != IOUDS_HUNG && (keyExt || keyQuick)
    |=> state != IOUDS_IDLE || $past(state) == IOUDS_START)
    else $error("key accepted during sequence");
  start_key_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == IOUDS_IDLE && keyExt |=> state == IOUDS_CLEAR && extRun)
    else $error("extended key not started");
  clock_chan_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> chanFull[CLK_CH] && chanFlag[CLK_CH] && chanActive[CLK_CH])
    else $error("clock channel flags altered");
  chan_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == IOUDS_CLEAR |=> !chanActive[0] && chanActive[1] && !chanFull[1])
    else $error("channel state after clear wrong");
  reg_init_a: assert property (@(posedge clk) disable iff (!rst_n)
    regLoad |-> regInit.counter == `IOUDS_IC_INIT && regInit.count == `IOUDS_WC_INIT
    && regInit.chan != 5'h00)
    else $error("bad register init");
  quick_path_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == IOUDS_IDLE && keyQuick |=> state == IOUDS_CLEAR ##20 state == IOUDS_LOAD)
    else $error("quick run entered extended steps");
  load_words_a: assert property (@(posedge clk) disable iff (!rst_n)
    memWrite.we && state == IOUDS_START |-> memWrite.addr == `IOUDS_PROG_LAST
    && memWrite.data == 16'h0000)
    else $error("word 21 not cleared");
  test_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == IOUDS_DIAG && bootPc == `IOUDS_TEST_DONE && !diagBranchFail && !diagDataFail
    && timer < DIAG_CYC |=> state == IOUDS_CLEAR ##1 equipReset)
    else $error("test end did not master clear");
  fold_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
    foldEnable[3] |=> storeAddrOut[23] == $past(foldForce[3]))
    else $error("fold bit 23 not forced");
endmodule

//--- verification/iouds_boot_model.sv
// stand-in for the boot processor test run and the block inputs
`timescale 1ns/1ns
module iouds_boot_model #(
  parameter int RUN_CYC = 30
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // sequencer side
  input  wire logic        bootStart,
  input  wire logic [15:0] bootCounter,
  input  wire logic [19:0] ppWaiting,
  input  wire logic        equipReset,
  output logic [15:0]      bootPc,
  output logic             diagBranchFail,
  output logic             diagDataFail,
  output logic [19:0]      blockDone,
  // bench control: 0 sound, 1 branch fault, 2 data fault, 3 hang
  input  wire logic [1:0]  failMode,
  input  wire logic        feed
);
  int   runCnt;
  logic running;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      running <= 1'b0;
      runCnt <= 0;
      bootPc <= 16'h0000;
      diagBranchFail <= 1'b0;
      diagDataFail <= 1'b0;
    end else if (equipReset) begin
      // master clear wipes the boot processor, so no stale pc or fault reaches the next run
      running <= 1'b0;
      runCnt <= 0;
      bootPc <= 16'h0000;
      diagBranchFail <= 1'b0;
      diagDataFail <= 1'b0;
    end else if (bootStart && bootCounter != 16'h0000) begin
      running <= 1'b1;
      runCnt <= 0;
      bootPc <= bootCounter;
      diagBranchFail <= 1'b0;
      diagDataFail <= 1'b0;
    end else if (running) begin
      runCnt <= runCnt + 1;
      bootPc <= bootPc + 16'h0001;
      if (runCnt == RUN_CYC) begin
        running <= 1'b0;
        // a faulty test never reaches its last word
        if (failMode == 2'h0) bootPc <= 16'o007776;
        diagBranchFail <= (failMode == 2'h1);
        diagDataFail <= (failMode == 2'h2);
      end
    end
  end
  // every waiting processor gets its block once feed is raised
  always_ff @(posedge clk) begin
    if (!rst_n) blockDone <= '0;
    else blockDone <= feed ? ppWaiting : '0;
  end
endmodule

//--- verification/iouds_sequencer_bench.sv
// self-checking bench of the deadstart sequencer
`timescale 1ns/1ns
`include "iouds_defs.svh"
module iouds_sequencer_bench import iouds_pkg::*;;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, regLoad, bootStart, equipReset, maintBit52, dBr, dDa;
  logic        feed = 1'b0, sawEq, errSeen;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] bootCounter, bootPc, firstCnt, lastCnt;
  logic [27:0] storeAddrIn = 28'h0, storeAddrOut;
  logic [23:0] chanActive, chanFull, chanFlag, chanErr;
  logic [19:0] ppWaiting, blockDone;
  logic [4:0]  regPp, rot = 5'h00;
  logic [1:0]  failMode = 2'h0;
  iouds_mem_s  memWrite;
  iouds_regs_s regInit;
  logic [15:0] bootMem [0:17];
  logic [15:0] prog [0:15];
  int          err_total = 0, num_checks = 0, cyc = 0, t0;
  int          nLoad, badLoad, nWipe, nBad, nStart;

  iouds_sequencer #(.NUM_PP(20), .NUM_CHAN(24), .DIAG_CYC(32'd200)) i_iouds_sequencer (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .memWrite(memWrite), .regLoad(regLoad), .regInit(regInit), .regPp(regPp),
    .bootStart(bootStart), .bootCounter(bootCounter), .bootPc(bootPc),
    .diagBranchFail(dBr), .diagDataFail(dDa), .equipReset(equipReset),
    .maintBit52(maintBit52), .chanActive(chanActive), .chanFull(chanFull),
    .chanFlag(chanFlag), .chanErr(chanErr), .ppWaiting(ppWaiting),
    .blockDone(blockDone), .storeAddrIn(storeAddrIn), .storeAddrOut(storeAddrOut));
  iouds_boot_model i_iouds_boot_model (
    .clk(clk), .rst_n(rst_n), .bootStart(bootStart), .bootCounter(bootCounter),
    .ppWaiting(ppWaiting), .equipReset(equipReset), .bootPc(bootPc),
    .diagBranchFail(dBr), .diagDataFail(dDa),
    .blockDone(blockDone), .failMode(failMode), .feed(feed));

  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // watch memory writes, register loads and starts
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
    if (memWrite.we && memWrite.addr == 12'o7777) nWipe++;
    else if (memWrite.we && memWrite.pp == rot && memWrite.addr <= 12'o0021)
      bootMem[memWrite.addr] = memWrite.data;
    else if (memWrite.we) nBad++;
    if (regLoad) nLoad++;
    if (regLoad && (regInit.opcode !== `IOUDS_OPC_INIT || regInit.counter !== `IOUDS_IC_INIT
        || regInit.count !== `IOUDS_WC_INIT || regInit.chan !== 5'((regPp + 20 - rot) % 20)))
      badLoad++;
    if (bootStart) begin
      nStart++;
      lastCnt = bootCounter;
      if (nStart == 1) firstCnt = bootCounter;
    end
    if (equipReset) sawEq = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdChk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    do begin
      apb(1'b0, `IOUDS_STAT_OFF, 32'h0);
      n++;
    end while (rd[2:0] !== 3'b000 && n < 1000);
  endtask
  task automatic clrMon();
    nLoad = 0;
    badLoad = 0;
    nWipe = 0;
    nBad = 0;
    nStart = 0;
    sawEq = 1'b0;
    for (int i = 0; i < 18; i++) bootMem[i] = 16'hFFFF;
  endtask
  task automatic foldCase(input logic [31:0] f, input logic [27:0] a, input logic [27:0] e);
    wr(`IOUDS_FOLD_OFF, f);
    storeAddrIn <= a;
    repeat (3) @(posedge clk);
    chk("folded address", 32'(e), 32'(storeAddrOut));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clrMon();
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdChk("status", `IOUDS_STAT_OFF, 32'h0);
    rdChk("config", `IOUDS_CONF_OFF, {`IOUDS_LT_ENTRY, 16'h0000});
    chk("clock channel", 32'h1000, 32'(chanFull & chanFlag & chanErr & chanActive));
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped error", 32'h1, 32'(errSeen));
    wr(`IOUDS_BLOCK_OFF, 32'h0010_0000);
    for (int i = 0; i < 16; i++) begin
      prog[i] = 16'h1000 + 16'(i * 17);
      wr(`IOUDS_BLOCK_OFF, {16'h0000, prog[i]});
    end
    prog[5] = 16'hA5A5;
    wr(`IOUDS_EDIT_OFF, 32'h0005_A5A5);
    for (int i = 0; i < 16; i++)
      rdChk("program word", 12'h040 + 12'(4 * i), {16'h0000, prog[i]});
    foldCase(32'h88, 28'h0000123, 28'h0800123);
    foldCase(32'h80, 28'h0ABCDEF, 28'h02BCDEF);
    foldCase(32'hF5, 28'h0ABCDEF, 28'h05BCDEF);
    foldCase(32'h00, 28'h0ABCDEF, 28'h0ABCDEF);
    wr(`IOUDS_CONF_OFF, {`IOUDS_LT_ENTRY, 16'h0014});
    apb(1'b0, `IOUDS_STAT_OFF, 32'h0);
    chk("config error", 32'h1, 32'(rd[6]));
    rdChk("config", `IOUDS_CONF_OFF, {`IOUDS_LT_ENTRY, 16'h0000});
    wr(`IOUDS_CONF_OFF, {`IOUDS_LT_ENTRY, 16'h0000});
    rdChk("status", `IOUDS_STAT_OFF, 32'h0);
    // quick run
    wr(`IOUDS_CTRL_OFF, 32'h1);
    waitIdle();
    chk("clear loads", 32'd19, nLoad);
    chk("load values", 32'h0, badLoad);
    chk("stray writes", 32'h0, nBad + nWipe);
    chk("boot word 0", 32'h0, bootMem[0]);
    chk("boot word 21", 32'h0, bootMem[17]);
    for (int i = 0; i < 16; i++) chk("boot word", prog[i], bootMem[i + 1]);
    chk("start address", 32'h0, lastCnt);
    chk("equipment reset", 32'h1, 32'(sawEq & maintBit52));
    chk("active", 32'hFFFFFE, chanActive);
    chk("full", 32'h1000, chanFull);
    chk("flag", 32'h1000, chanFlag);
    chk("error flag", 32'h1000, chanErr);
    chk("waiting", 32'hFFFFE, ppWaiting);
    wr(`IOUDS_CTRL_OFF, 32'h3);
    wr(`IOUDS_CTRL_OFF, 32'h0);
    repeat (40) @(posedge clk);
    chk("starts", 32'h1, nStart);
    feed <= 1'b1;
    repeat (3) @(posedge clk);
    feed <= 1'b0;
    chk("waiting", 32'h0, ppWaiting);
    // extended run with a second key while busy
    clrMon();
    wr(`IOUDS_CTRL_OFF, 32'h2);
    wr(`IOUDS_CTRL_OFF, 32'h1);
    waitIdle();
    repeat (60) @(posedge clk);
    chk("wiped words", 32'd20, nWipe);
    chk("clear loads", 32'd38, nLoad);
    chk("starts", 32'h2, nStart);
    chk("entry point", `IOUDS_LT_ENTRY, firstCnt);
    chk("start address", 32'h0, lastCnt);
    chk("load values", 32'h0, badLoad + nBad);
    for (int m = 1; m < 3; m++) begin
      failMode <= 2'(m);
      wr(`IOUDS_CTRL_OFF, 32'h2);
      waitIdle();
      rdChk("fault display", `IOUDS_FAULT_OFF, 32'(m));
    end
    failMode <= 2'h3;
    clrMon();
    t0 = cyc;
    wr(`IOUDS_CTRL_OFF, 32'h2);
    waitIdle();
    chk("hung starts", 32'h1, nStart);
    chk("diagnostic span", 32'h1, 32'(cyc - t0 >= 200));
    failMode <= 2'h0;
    // rotated boot memory
    wr(`IOUDS_CONF_OFF, {`IOUDS_LT_ENTRY, 16'h0003});
    rot <= 5'h03;
    clrMon();
    wr(`IOUDS_CTRL_OFF, 32'h1);
    waitIdle();
    chk("rotated writes", 32'h0, nBad);
    chk("rotated word", prog[0], bootMem[1]);
    chk("rotated loads", 32'h0, badLoad);
    test_done();
  end
endmodule
